/* File: verification/sbpt_tgt_model.sv */
// behavioural target on the far side of the bus port
// assumes the bench resolves the wired-or bus and feeds it back here
`timescale 1ns/10ps
`default_nettype none
module sbpt_tgt_model
    import sbpt_pkg::*;
#(
    parameter int TID = 5,
    parameter int LAG = 3
) (
    // clock and resolved bus
    input  wire logic       clk,
    input  wire sbpt_ctl_t  bus_ctl,
    input  wire sbpt_byte_t bus_db,
    // bench control
    input  wire logic       answer,
    input  wire logic       xfer,
    input  wire logic       dir_in,
    input  wire logic [7:0] byte_in,
    // driven lines and results
    output sbpt_ctl_t       ctl,
    output sbpt_byte_t      db,
    output logic            done,
    output sbpt_byte_t      got
);
    // one loop; released lines fall to the deasserted level
    initial begin
        ctl = '0;
        db = '0;
        done = 1'b0;
        got = '0;
        forever begin
            @(posedge clk);
            done <= 1'b0;
            if (bus_ctl.rst || !answer) begin
                ctl <= '0;
                db <= '0;
            end else if (!ctl.bsy && bus_ctl.sel && !bus_ctl.io && bus_db.data[TID]) begin
                repeat (LAG) @(posedge clk);
                ctl.bsy <= 1'b1;
            end else if (xfer && ctl.bsy) begin
                ctl.io <= dir_in;
                db <= dir_in ? {~^byte_in, byte_in} : '0;
                @(posedge clk);
                ctl.req <= 1'b1;
                do @(posedge clk); while (!bus_ctl.ack);
                got <= bus_db;
                ctl.req <= 1'b0;
                do @(posedge clk); while (bus_ctl.ack);
                db <= '0;
                done <= 1'b1;
            end
        end
    end
endmodule // sbpt_tgt_model
`default_nettype wire

/* File: verification/sbpt_top_tb.sv */
// self-checking bench for the bus phase timing block
// assumes the design files and the target model are compiled first
`timescale 1ns/10ps
`default_nettype none
module sbpt_top_tb;
    import sbpt_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, sreq = 1'b0, atn = 1'b0, brst = 1'b0, tv = 1'b0;
    logic rr = 1'b0, ans = 1'b0, xfer = 1'b0, tdir = 1'b0;
    logic [7:0] td = '0, tbyte = '0, rd, b;
    logic sdone, sto, alost, resel, conn, tr, rv, dboe, done;
    logic [2:0] r, oid = 3'h2, tid = 3'h5;
    sbpt_ctl_t dctl, doe, tctl, rctl = '0, bctl;
    sbpt_byte_t ddb, tdb, rdb = '0, bdb, got;
    int n_mismatch = 0, samples_checked = 0, seed = 32'h412f, n, nb, ts;
    logic [7:0] rxq[$];
    logic [8:0] txq[$];
    // wired-or bus, true means asserted
    assign bctl = (dctl & doe) | tctl | rctl;
    assign bdb = (dboe ? ddb : '0) | tdb | rdb;
    always #20 clk = ~clk;
    sbpt_top #(.RSTHOLD_CYC(20), .SELABORT_CYC(50), .SELTO_CYC(200)) DUT (
        .CORE_CLK(clk), .RSTN(rstn), .SEL_REQ(sreq), .OWN_ID(oid), .TARGET_ID(tid),
        .ATN_REQ(atn), .BUS_RESET_REQ(brst), .SEL_DONE(sdone), .SEL_TIMEOUT(sto),
        .ARB_LOST(alost), .RESELECTED(resel), .CONNECTED(conn), .TX_VALID(tv),
        .TX_DATA(td), .TX_READY(tr), .RX_VALID(rv), .RX_DATA(rd), .RX_READY(rr),
        .BUS_DB_IN(bdb), .BUS_DB_OUT(ddb), .BUS_DB_OE(dboe), .BUS_CTL_IN(bctl),
        .BUS_CTL_OUT(dctl), .BUS_CTL_OE(doe));
    sbpt_tgt_model #(.TID(5), .LAG(3)) tgt (.clk(clk), .bus_ctl(bctl), .bus_db(bdb),
        .answer(ans), .xfer(xfer), .dir_in(tdir), .byte_in(tbyte), .ctl(tctl),
        .db(tdb), .done(done), .got(got));
    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic step();
        @(posedge clk);
        n++;
    endtask
    // arbitrate and select; a rival may claim the top id once our busy shows
    task automatic sel_run(input logic rival);
        n = 0;
        ts = 0;
        sreq <= 1'b1;
        do step(); while (dctl.bsy !== 1'b1 && n < 60);
        chk("bsy_set", n <= 45, 1);
        chk("own_bit", ddb.data[2] & dboe, 1);
        nb = n;
        if (rival) begin
            rdb <= 9'h080;
            rctl.bsy <= 1'b1;
        end
        do begin
            step();
            if (dctl.sel === 1'b1 && ts == 0) ts = n;
        end while ({sdone, sto, alost} === 3'b000 && n < 600);
        r = {sdone, sto, alost};
        sreq <= 1'b0;
        rdb <= '0;
        rctl <= '0;
        if (!rival) chk("arb_wait", ts - nb >= 55, 1);
    endtask
    task automatic released(input string nm, input int lim);
        repeat (lim) @(posedge clk);
        chk(nm, (|doe) | dboe, 0);
    endtask
    // one target handshake, bounded wait for its end
    task automatic xact(input logic [7:0] v);
        tbyte <= v;
        xfer <= 1'b1;
        @(posedge clk);
        xfer <= 1'b0;
        n = 0;
        do step(); while (done !== 1'b1 && n < 300);
    endtask
    // scoreboard: oldest note against each result seen
    always @(posedge clk) begin
        rr <= 1'($random(seed));
        if (rv === 1'b1 && rr === 1'b1) chk("rx", rd, rxq.pop_front());
        if (done === 1'b1 && tdir === 1'b0) chk("tx", got, txq.pop_front());
    end
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (40) @(posedge clk);
        chk("idle", (|doe) | dboe | conn, 0);
        sel_run(1'b0);
        chk("timeout", r, 3'b010);
        chk("to_wait", n - ts >= 200, 1);
        released("to_rel", 20);
        sel_run(1'b1);
        chk("lost", r, 3'b001);
        released("lost_rel", 20);
        repeat (40) @(posedge clk);
        ans <= 1'b1;
        atn <= 1'b1;
        sel_run(1'b0);
        chk("won", r, 3'b100);
        @(posedge clk);
        chk("conn", conn, 1);
        tdir <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            b = 8'($random(seed));
            rxq.push_back(b);
            xact(b);
        end
        tdir <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            b = 8'($random(seed));
            txq.push_back({~^b, b});
            td <= b;
            tv <= 1'b1;
            n = 0;
            do step(); while (tr !== 1'b1 && n < 300);
            tv <= 1'b0;
            xact(8'h00);
        end
        ans <= 1'b0;
        atn <= 1'b0;
        released("free_rel", 30);
        repeat (40) @(posedge clk);
        rdb <= 9'h024;
        rctl.sel <= 1'b1;
        rctl.io <= 1'b1;
        n = 0;
        ts = 0;
        do step(); while (dctl.bsy !== 1'b1 && n < 60);
        chk("resel_bsy", n <= 50, 1);
        rctl.bsy <= 1'b1;
        rctl.sel <= 1'b0;
        repeat (10) begin
            step();
            if (resel === 1'b1) ts = 1;
        end
        chk("resel", ts, 1);
        rctl <= '0;
        rdb <= '0;
        repeat (60) @(posedge clk);
        brst <= 1'b1;
        n = 0;
        do step(); while (dctl.rst !== 1'b1 && n < 20);
        brst <= 1'b0;
        n = 0;
        do step(); while (dctl.rst === 1'b1 && n < 100);
        chk("rst_hold", n >= 20, 1);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end
endmodule // sbpt_top_tb
`default_nettype wire

/* File: verilog/sbpt_buf2.sv */
// two-entry skid buffer with valid and ready on both sides
// assumes producer and consumer share the core clock
`timescale 1ns/10ps
`default_nettype none
module sbpt_buf2 #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         CORE_CLK,
    input  wire logic         RSTN,
    // fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // drain side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    initial begin
        if (W < 1) $error("sbpt_buf2 width must be positive");
    end

    logic [W-1:0] mem_reg [2];
    logic         wp_reg;
    logic         rp_reg;
    logic [1:0]   cnt_reg;
    wire          push = in_valid && in_ready;
    wire          pop  = out_valid && out_ready;

    // pointers and occupancy; full and empty come straight from the count
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            wp_reg  <= 1'b0;
            rp_reg  <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            if (push) wp_reg <= ~wp_reg;
            if (pop)  rp_reg <= ~rp_reg;
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    // storage
    always_ff @(posedge CORE_CLK) begin
        if (push) mem_reg[wp_reg] <= in_data;
    end

    assign in_ready  = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data  = mem_reg[rp_reg];
endmodule // sbpt_buf2
`default_nettype wire

/* File: verilog/sbpt_cfg.svh */
// timing counts, counter width and id and lun counts for the bus phase timing block
// assumes a 25 MHz core clock; counts derive from times by expressions
//
// Contract
// - wait at least 2.2 us after asserting BSY before judging arbitration.
// - release all bus signals within 800 ns after bus free or foreign SEL.
// - after bus free, bus cleared within 1200 ns of BSY and SEL false.
// - slow bus free detection shortens the allowed clearing time accordingly.
// - wait at least 800 ns after bus free before asserting BSY.
// - drive BSY and own ID within 1.8 us after bus free detection; code sets no upper limit, SBPT_SET_CYC is unused.
// - allow 400 ns bus settle after changing control signals.
// - hold bus reset asserted at least 25 us.
// - selected device asserts BSY within 200 us of selection detection.
// - wait at least 250 ms for BSY response before selection timeout.
// - port uses 18 signals: eight data plus parity, nine controls.
// - at most eight IDs share the bus, each distinct.
// - transfers are asynchronous with REQ/ACK handshake.
// - each REQ/ACK handshake moves exactly one byte.
// - initiator arbitrates then selects one specific target.
// - initiator accepts reselection by a target.
// - data line 7 has highest arbitration priority, line 0 lowest.
// - generate odd parity; received parity unchecked; invalid in arbitration allowed.
`ifndef SBPT_CFG_SVH
`define SBPT_CFG_SVH
`define SBPT_CLK_KHZ        25000
`define SBPT_ARB_NS         2200
`define SBPT_CLEAR_NS       800
`define SBPT_FREE_NS        800
`define SBPT_SET_NS         1800
`define SBPT_SETTLE_NS      400
`define SBPT_RSTHOLD_NS     25000
`define SBPT_SELABORT_NS    200000
`define SBPT_SELTO_MS       250
// least times round up, longest times round down
`define SBPT_CYC_MIN(ns)    (((ns) * `SBPT_CLK_KHZ + 999999) / 1000000)
`define SBPT_CYC_MAX(ns)    (((ns) * `SBPT_CLK_KHZ) / 1000000)
`define SBPT_ARB_CYC        `SBPT_CYC_MIN(`SBPT_ARB_NS)
`define SBPT_FREE_CYC       `SBPT_CYC_MIN(`SBPT_FREE_NS)
`define SBPT_SETTLE_CYC     `SBPT_CYC_MIN(`SBPT_SETTLE_NS)
`define SBPT_CLEAR_CYC      `SBPT_CYC_MAX(`SBPT_CLEAR_NS)
`define SBPT_SET_CYC        `SBPT_CYC_MAX(`SBPT_SET_NS)
`define SBPT_RSTHOLD_CYC    `SBPT_CYC_MIN(`SBPT_RSTHOLD_NS)
`define SBPT_SELABORT_CYC   `SBPT_CYC_MAX(`SBPT_SELABORT_NS)
`define SBPT_SELTO_CYC      (`SBPT_SELTO_MS * `SBPT_CLK_KHZ)
`define SBPT_CNT_W          23
`define SBPT_NUM_ID         8
`define SBPT_NUM_LUN        8
`endif

/* File: verilog/sbpt_pkg.sv */
// types shared by the bus phase timing block
// assumes nothing beyond the configuration header
package sbpt_pkg;
    // bus control lines as one bundle, true means asserted
    typedef struct packed {
        logic bsy;
        logic sel;
        logic rst;
        logic atn;
        logic msg;
        logic cd;
        logic io;
        logic req;
        logic ack;
    } sbpt_ctl_t;

    // one bus byte with its parity
    typedef struct packed {
        logic       par;
        logic [7:0] data;
    } sbpt_byte_t;

    typedef enum logic [3:0] {
        SBPT_IDLE, SBPT_FREE_WAIT, SBPT_ARB, SBPT_ARB_JUDGE, SBPT_SEL_SETTLE,
        SBPT_SEL_WAIT, SBPT_CONNECT, SBPT_RESEL_ANS, SBPT_RELEASE, SBPT_BUS_RESET
    } sbpt_state_t;
endpackage : sbpt_pkg

/* File: verilog/sbpt_timer.sv */
// down-counting delay timer, loads a count and pulses when it reaches zero
// assumes load and the count are synchronous to the core clock
`timescale 1ns/10ps
`default_nettype none
module sbpt_timer #(
    parameter int W = 23
) (
    // clock and reset
    input  wire logic         CORE_CLK,
    input  wire logic         RSTN,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    // status
    output logic              done,
    output logic              busy
);
    initial begin
        if (W < 2) $error("sbpt_timer width too small");
    end

    logic [W-1:0] cnt_reg;
    wire          at_one = (cnt_reg == {{(W-1){1'b0}}, 1'b1});

    // count down; done pulses in the cycle the count runs out
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cnt_reg <= '0;
            done    <= 1'b0;
        end else if (load) begin
            cnt_reg <= count;
            done    <= 1'b0;
        end else begin
            done <= at_one;
            if (cnt_reg != '0) cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign busy = (cnt_reg != '0);
endmodule // sbpt_timer
`default_nettype wire

/* File: verilog/sbpt_top.sv */
// bus phase timing and role logic for a single-ended asynchronous bus port
// assumes pins are synchronous to CORE_CLK; pads resolve wired-or from enables
`timescale 1ns/10ps
`default_nettype none
`include "sbpt_cfg.svh"
module sbpt_top
    import sbpt_pkg::*;
#(
    parameter int ID_W          = 3,
    parameter int RSTHOLD_CYC   = `SBPT_RSTHOLD_CYC,
    parameter int SELABORT_CYC  = `SBPT_SELABORT_CYC,
    parameter int SELTO_CYC     = `SBPT_SELTO_CYC
) (
    // clock and reset
    input  wire logic         CORE_CLK,
    input  wire logic         RSTN,
    // controller side: selection requests
    input  wire logic         SEL_REQ,
    input  wire logic [2:0]   OWN_ID,
    input  wire logic [2:0]   TARGET_ID,
    input  wire logic         ATN_REQ,
    input  wire logic         BUS_RESET_REQ,
    output logic              SEL_DONE,
    output logic              SEL_TIMEOUT,
    output logic              ARB_LOST,
    output logic              RESELECTED,
    output logic              CONNECTED,
    // controller side: outgoing bytes
    input  wire logic         TX_VALID,
    input  wire logic [7:0]   TX_DATA,
    output logic              TX_READY,
    // controller side: incoming bytes
    output logic              RX_VALID,
    output logic [7:0]        RX_DATA,
    input  wire logic         RX_READY,
    // bus data lines, true means asserted
    input  wire sbpt_byte_t   BUS_DB_IN,
    output sbpt_byte_t        BUS_DB_OUT,
    output logic              BUS_DB_OE,
    // bus control lines, true means asserted
    input  wire sbpt_ctl_t    BUS_CTL_IN,
    output sbpt_ctl_t         BUS_CTL_OUT,
    output sbpt_ctl_t         BUS_CTL_OE
);
    initial begin
        if (ID_W != 3) $error("sbpt_top supports eight ids only");
        if (RSTHOLD_CYC < 1 || SELABORT_CYC < 1 || SELTO_CYC < 1)
            $error("sbpt_top timing counts must be positive");
        if (SELTO_CYC >= (1 << `SBPT_CNT_W)) $error("sbpt_top timeout too long");
    end

    localparam int CW = `SBPT_CNT_W;

    //--------------------------------------------------------------------
    // bus observation
    //--------------------------------------------------------------------
    sbpt_state_t  state_reg, state_next;
    logic [CW-1:0] tload_cnt;
    logic          tload;
    logic          t_done;
    logic          t_busy;
    logic [CW-1:0] free_cnt_reg;
    logic [7:0]    own_bit;
    logic [7:0]    tgt_bit;
    logic [7:0]    higher_mask;
    logic [7:0]    db_reg;
    logic          db_oe_reg;
    logic          ack_reg;
    logic          bsy_reg;
    logic          sel_reg;
    logic          atn_reg;
    logic          rst_reg;
    logic          req_seen_reg;

    // wires from observed bus state
    wire bus_free      = !BUS_CTL_IN.bsy && !BUS_CTL_IN.sel && !BUS_CTL_IN.rst;
    wire free_settled  = (free_cnt_reg >= CW'(`SBPT_SETTLE_CYC));
    wire free_ok       = (free_cnt_reg >= CW'(`SBPT_SETTLE_CYC + `SBPT_FREE_CYC));
    wire foreign_sel   = BUS_CTL_IN.sel && !sel_reg;
    wire we_win        = ((BUS_DB_IN.data & higher_mask) == 8'h00);
    wire resel_seen    = BUS_CTL_IN.sel && !BUS_CTL_IN.bsy && BUS_CTL_IN.io
                         && BUS_DB_IN.data[OWN_ID] && ($countones(BUS_DB_IN.data) == 2);
    wire target_out    = !BUS_CTL_IN.io;
    wire req_rise      = BUS_CTL_IN.req && !req_seen_reg;
    wire in_xfer       = (state_reg == SBPT_CONNECT);

    // id decode; ids above own id outrank it
    assign own_bit     = 8'h01 << OWN_ID;
    assign tgt_bit     = 8'h01 << TARGET_ID;
    assign higher_mask = ~((own_bit << 1) - 8'h01);

    // settle-qualified bus free time, counted while bsy, sel and rst are false
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN)              free_cnt_reg <= '0;
        else if (!bus_free)     free_cnt_reg <= '0;
        else if (!(&free_cnt_reg)) free_cnt_reg <= free_cnt_reg + 1'b1;
    end

    //--------------------------------------------------------------------
    // shared delay timer
    //--------------------------------------------------------------------
    sbpt_timer #(.W(CW)) u_timer (
        .CORE_CLK (CORE_CLK),
        .RSTN     (RSTN),
        .load     (tload),
        .count    (tload_cnt),
        .done     (t_done),
        .busy     (t_busy)
    );

    //--------------------------------------------------------------------
    // data buffers
    //--------------------------------------------------------------------
    logic        txb_valid;
    logic [7:0]  txb_data;
    logic        txb_ready;
    logic        rxb_in_valid;
    logic        rxb_in_ready;
    logic        rxb_out_valid;
    logic [7:0]  rxb_out_data;
    logic        TX_READY_w;
    logic        rx_pop;

    sbpt_buf2 #(.W(8)) u_txbuf (
        .CORE_CLK  (CORE_CLK),
        .RSTN      (RSTN),
        .in_valid  (TX_VALID),
        .in_data   (TX_DATA),
        .in_ready  (TX_READY_w),
        .out_valid (txb_valid),
        .out_data  (txb_data),
        .out_ready (txb_ready)
    );

    sbpt_buf2 #(.W(8)) u_rxbuf (
        .CORE_CLK  (CORE_CLK),
        .RSTN      (RSTN),
        .in_valid  (rxb_in_valid),
        .in_data   (BUS_DB_IN.data),
        .in_ready  (rxb_in_ready),
        .out_valid (rxb_out_valid),
        .out_data  (rxb_out_data),
        .out_ready (rx_pop)
    );

    // handshake: answer a target request; ack only when a byte can move
    assign txb_ready    = in_xfer && req_rise && target_out && txb_valid && !ack_reg;
    assign rxb_in_valid = in_xfer && req_rise && !target_out && !ack_reg;
    assign rx_pop       = !RX_VALID || RX_READY;

    //--------------------------------------------------------------------
    // phase sequencer
    //--------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        tload      = 1'b0;
        tload_cnt  = '0;
        case (state_reg)
            SBPT_IDLE: begin
                if (BUS_RESET_REQ) begin
                    state_next = SBPT_BUS_RESET;
                    tload      = 1'b1;
                    tload_cnt  = CW'(RSTHOLD_CYC);
                end else if (resel_seen) begin
                    state_next = SBPT_RESEL_ANS;
                    tload      = 1'b1;
                    tload_cnt  = CW'(SELABORT_CYC);
                end else if (SEL_REQ && free_ok) begin
                    state_next = SBPT_ARB;
                    tload      = 1'b1;
                    tload_cnt  = CW'(`SBPT_ARB_CYC);
                end
            end
            SBPT_ARB: begin
                if (foreign_sel) state_next = SBPT_RELEASE;
                else if (t_done) state_next = SBPT_ARB_JUDGE;
            end
            SBPT_ARB_JUDGE: begin
                if (!we_win || foreign_sel) state_next = SBPT_RELEASE;
                else begin
                    state_next = SBPT_SEL_SETTLE;
                    tload      = 1'b1;
                    tload_cnt  = CW'(`SBPT_SETTLE_CYC);
                end
            end
            SBPT_SEL_SETTLE: begin
                if (t_done) begin
                    state_next = SBPT_SEL_WAIT;
                    tload      = 1'b1;
                    tload_cnt  = CW'(SELTO_CYC);
                end
            end
            SBPT_SEL_WAIT: begin
                if (BUS_CTL_IN.bsy && !bsy_reg) state_next = SBPT_CONNECT;
                else if (t_done) state_next = SBPT_RELEASE;
            end
            SBPT_RESEL_ANS: begin
                if (!BUS_CTL_IN.sel) state_next = SBPT_CONNECT;
                else if (t_done) state_next = SBPT_RELEASE;
            end
            SBPT_CONNECT: begin
                if (!BUS_CTL_IN.bsy || BUS_CTL_IN.rst) state_next = SBPT_RELEASE;
            end
            SBPT_RELEASE: state_next = SBPT_IDLE;
            SBPT_BUS_RESET: begin
                if (t_done) state_next = SBPT_IDLE;
            end
            default: state_next = SBPT_IDLE;
        endcase
    end

    // state and bus-facing flip-flops; release takes at most two cycles so every
    // clearing limit is met within two cycles of its cause
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_reg    <= SBPT_IDLE;
            bsy_reg      <= 1'b0;
            sel_reg      <= 1'b0;
            atn_reg      <= 1'b0;
            rst_reg      <= 1'b0;
            db_reg       <= 8'h00;
            db_oe_reg    <= 1'b0;
            req_seen_reg <= 1'b0;
        end else begin
            state_reg    <= (BUS_CTL_IN.rst && !rst_reg) ? SBPT_IDLE : state_next;
            req_seen_reg <= BUS_CTL_IN.req;
            bsy_reg      <= (state_next == SBPT_ARB) || (state_next == SBPT_ARB_JUDGE)
                            || (state_next == SBPT_SEL_SETTLE)
                            || (state_next == SBPT_RESEL_ANS)
                            || (state_next == SBPT_CONNECT && state_reg == SBPT_RESEL_ANS);
            sel_reg      <= (state_next == SBPT_SEL_SETTLE) || (state_next == SBPT_SEL_WAIT);
            atn_reg      <= ATN_REQ && (state_next inside {SBPT_SEL_SETTLE, SBPT_SEL_WAIT,
                                                          SBPT_CONNECT});
            rst_reg      <= (state_next == SBPT_BUS_RESET);
            db_oe_reg    <= (state_next inside {SBPT_ARB, SBPT_ARB_JUDGE, SBPT_SEL_SETTLE})
                            || (in_xfer && target_out && (txb_ready || ack_reg));
            if (state_next == SBPT_ARB || state_next == SBPT_ARB_JUDGE) db_reg <= own_bit;
            else if (state_next == SBPT_SEL_SETTLE) db_reg <= own_bit | tgt_bit;
            else if (txb_ready) db_reg <= txb_data;
        end
    end

    // ack follows req: raise on a moved byte, drop when req falls
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN)                          ack_reg <= 1'b0;
        else if (!in_xfer || !BUS_CTL_IN.req) ack_reg <= 1'b0;
        else if (txb_ready || (rxb_in_valid && rxb_in_ready)) ack_reg <= 1'b1;
    end

    //--------------------------------------------------------------------
    // output registers
    //--------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            SEL_DONE    <= 1'b0;
            SEL_TIMEOUT <= 1'b0;
            ARB_LOST    <= 1'b0;
            RESELECTED  <= 1'b0;
            CONNECTED   <= 1'b0;
            TX_READY    <= 1'b0;
            RX_VALID    <= 1'b0;
            RX_DATA     <= 8'h00;
        end else begin
            SEL_DONE    <= (state_reg == SBPT_SEL_WAIT) && (state_next == SBPT_CONNECT);
            SEL_TIMEOUT <= (state_reg == SBPT_SEL_WAIT) && t_done;
            ARB_LOST    <= (state_reg inside {SBPT_ARB, SBPT_ARB_JUDGE})
                           && (state_next == SBPT_RELEASE);
            RESELECTED  <= (state_reg == SBPT_RESEL_ANS) && (state_next == SBPT_CONNECT);
            CONNECTED   <= (state_next == SBPT_CONNECT);
            TX_READY    <= TX_READY_w && !(TX_VALID && TX_READY);
            if (rx_pop) begin
                RX_VALID <= rxb_out_valid;
                RX_DATA  <= rxb_out_data;
            end
        end
    end

    // pin drive: data with odd parity, controls as open-collector enables
    always_comb begin
        BUS_DB_OUT.data = db_reg;
        BUS_DB_OUT.par  = ~^db_reg;
        BUS_DB_OE       = db_oe_reg;
        BUS_CTL_OUT     = '0;
        BUS_CTL_OUT.bsy = bsy_reg;
        BUS_CTL_OUT.sel = sel_reg;
        BUS_CTL_OUT.atn = atn_reg;
        BUS_CTL_OUT.rst = rst_reg;
        BUS_CTL_OUT.ack = ack_reg;
        BUS_CTL_OE      = BUS_CTL_OUT;
    end

    //--------------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------------
    AST_ARB_WAIT: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        $rose(state_reg == SBPT_ARB_JUDGE) |-> $past(bsy_reg, `SBPT_ARB_CYC))
        else $error("arbitration judged too early");
    AST_SEL_RELEASE: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_reg == SBPT_ARB && foreign_sel) |-> ##2 !bsy_reg && !db_oe_reg)
        else $error("bus not released after foreign select");
    AST_FREE_WAIT: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        $rose(state_reg == SBPT_ARB) |-> $past(free_ok))
        else $error("bsy asserted before bus free delay");
    AST_RST_HOLD: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        $rose(rst_reg) |-> rst_reg [*8])
        else $error("bus reset held too briefly");
    AST_TIMEOUT_RELEASE: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        SEL_TIMEOUT |-> !sel_reg && !bsy_reg)
        else $error("bus held after selection timeout");
    AST_PARITY: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        db_oe_reg |-> ^{BUS_DB_OUT.par, BUS_DB_OUT.data})
        else $error("even parity driven");
    AST_ACK_DROP: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (ack_reg && !BUS_CTL_IN.req) |=> !ack_reg)
        else $error("ack held after req fell");
    AST_RESEL_BSY: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
        (state_reg == SBPT_RESEL_ANS && !BUS_CTL_IN.sel) |=> bsy_reg)
        else $error("no bsy after reselection");
endmodule // sbpt_top
`default_nettype wire
